// ===== rtl/fan_event_pkg.sv
// Package with register map, flag positions and shared types of the event status block.
package fan_event_pkg;
	localparam logic [7:0] STATUS_TWO_ADDR   = 8'h42;
	localparam logic [7:0] VOLT_CODE_ADDR    = 8'h43;
	localparam logic [7:0] STATUS_TWO_RESET  = 8'h00;
	localparam logic [7:0] DIODE_FAULT_VALUE = 8'h80;
	localparam int         RAIL_BIT          = 0;
	localparam int         RSVD_BIT          = 1;
	localparam int         FAN_BIT0          = 2;
	localparam int         DIODE1_BIT        = 6;
	localparam int         DIODE2_BIT        = 7;
	localparam int         FAN_COUNT         = 4;
	localparam int         CODE_WIDTH        = 5;

	// Per-source readings that arrive from the measurement units, then the host port state.
	typedef struct packed {
		logic [7:0] rail_reading;
		logic [7:0] rail_low;
		logic [7:0] rail_high;
		logic       rail_update;
	} rail_in_t;

	typedef struct packed {
		logic [15:0] count;
		logic [15:0] minimum;
		logic        update;
	} fan_in_t;

	typedef struct packed {
		logic [7:0] flags;
		logic [7:0] rdata;
		logic       rd_prev;
	} status_state_t;
endpackage : fan_event_pkg

// ===== rtl/event_flag_cell.sv
// One sticky status flag with enable, update and clear-on-read behaviour.
`timescale 1ns/1ps
module event_flag_cell (
	input  wire logic clk,        // Block clock.
	input  wire logic rst_n,      // Synchronised active-low reset.
	input  wire logic start,      // Monitoring started.
	input  wire logic enable,     // Individual enable.
	input  wire logic update,     // Associated reading register updated.
	input  wire logic condition,  // Event condition currently present.
	input  wire logic rd_clear,   // Clear-on-read strobe.
	input  wire logic dis_clear,  // Immediate clear when enable drops.
	output logic      flag        // Sticky flag.
);
	typedef struct packed {
		logic flag;
	} cell_state_t;

	cell_state_t s_q;
	cell_state_t s_d;

	// Set wins over every clear so an event in the clear cycle is kept.
	always_comb begin
		s_d = s_q;
		if (rd_clear && !condition) begin
			s_d.flag = 1'b0;
		end
		if (dis_clear || (!enable && start && update)) begin
			s_d.flag = 1'b0;
		end
		if (start && enable && update && condition) begin
			s_d.flag = 1'b1;
		end
	end

	// State register; reset leaves the flag clear.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign flag = s_q.flag;

	// A rise needs both enable and start one cycle earlier.
	a_flag_no_raise: assert property (@(posedge clk) disable iff (!rst_n)
		!$past(flag) && flag |-> $past(enable) && $past(start))
		else $error("Flag rose while disabled or stopped.");
	a_flag_keep: assert property (@(posedge clk) disable iff (!rst_n)
		$past(flag) && $past(condition) && !$past(dis_clear) && $past(enable) |-> flag)
		else $error("Flag dropped while its condition persisted.");
endmodule : event_flag_cell

// ===== rtl/fan_voltage_event_status.sv
// Second event status register and voltage code register with host port.
`timescale 1ns/1ps
module fan_voltage_event_status (
	input  wire logic                   MCLK,            // 10 MHz clock.
	input  wire logic                   RST_N,           // Async active-low reset.
	input  wire logic                   START,           // Monitoring start bit.
	input  wire logic [7:0]             ENABLES,         // Individual enables, bit per flag.
	input  fan_event_pkg::rail_in_t     RAIL,            // Twelve-volt reading and limits.
	input  fan_event_pkg::fan_in_t [3:0] FANS,           // Fan counts and minimums.
	input  wire logic                   DIODE_ONE_FAULT, // Diode one fault condition.
	input  wire logic                   DIODE_TWO_FAULT, // Diode two fault condition.
	input  wire logic [1:0]             DIODE_UPDATE,    // Diode reading updates.
	input  wire logic [4:0]             CPU_VOLTAGE_CODE, // Voltage code pins.
	input  wire logic [7:0]             ADDR,            // Host register address.
	input  wire logic                   RD_STB,          // Host read strobe.
	input  wire logic                   WR_STB,          // Host write strobe.
	output logic [7:0]                  RDATA,           // Captured read data.
	output logic                        SECOND_STATUS_SUMMARY, // Summary bit for status one.
	output logic [1:0]                  DIODE_FORCE,     // Force diode reading to fault value.
	output logic [7:0]                  DIODE_FORCE_VALUE, // Value to load on force.
	output logic [1:0]                  DIODE_LIMIT_CLR  // Clear diode limit error flags.
);
	logic [1:0] rst_sync_q;
	logic       rst_n_i;
	logic [4:0] code_meta_q;
	logic [4:0] code_sync_q;
	logic [7:0] cond;
	logic [7:0] upd;
	logic [7:0] flags;
	logic [7:0] en_prev_q;
	logic       rd_clear;
	fan_event_pkg::status_state_t s_q;
	fan_event_pkg::status_state_t s_d;

	// Reset release through two flops so every flop leaves reset together.
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n_i = rst_sync_q[1];

	// Pin levels from the processor are asynchronous, hence two flops.
	always_ff @(posedge MCLK or negedge rst_n_i) begin
		if (!rst_n_i) begin
			code_meta_q <= 5'h00;
			code_sync_q <= 5'h00;
			en_prev_q   <= 8'h00;
		end else begin
			code_meta_q <= CPU_VOLTAGE_CODE;
			code_sync_q <= code_meta_q;
			en_prev_q   <= ENABLES;
		end
	end

	// Event conditions per flag position.
	always_comb begin
		cond = 8'h00;
		upd  = 8'h00;
		cond[fan_event_pkg::RAIL_BIT] = (RAIL.rail_reading <= RAIL.rail_low) ||
			(RAIL.rail_reading > RAIL.rail_high);
		upd[fan_event_pkg::RAIL_BIT]  = RAIL.rail_update;
		cond[fan_event_pkg::DIODE1_BIT] = DIODE_ONE_FAULT;
		cond[fan_event_pkg::DIODE2_BIT] = DIODE_TWO_FAULT;
		upd[fan_event_pkg::DIODE1_BIT]  = DIODE_UPDATE[0];
		upd[fan_event_pkg::DIODE2_BIT]  = DIODE_UPDATE[1];
		for (int i = 0; i < fan_event_pkg::FAN_COUNT; i++) begin
			cond[fan_event_pkg::FAN_BIT0 + i] = FANS[i].count > FANS[i].minimum;
			upd[fan_event_pkg::FAN_BIT0 + i]  = FANS[i].update;
		end
	end

	// Clear fires once, on the cycle after the read data were captured.
	assign rd_clear = s_q.rd_prev;

	// One flag cell per status bit; the reserved position is a constant zero.
	// Only the diode flags take the immediate clear, the others wait for an update.
	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_flag
			if (g == fan_event_pkg::RSVD_BIT) begin : g_rsvd
				assign flags[g] = 1'b0;
			end else begin : g_cell
				logic is_diode;
				assign is_diode = (g == fan_event_pkg::DIODE1_BIT) ||
					(g == fan_event_pkg::DIODE2_BIT);
				event_flag_cell u_cell (
					.clk       (MCLK),
					.rst_n     (rst_n_i),
					.start     (START),
					.enable    (ENABLES[g]),
					.update    (upd[g]),
					.condition (cond[g]),
					.rd_clear  (rd_clear),
					.dis_clear (is_diode && en_prev_q[g] && !ENABLES[g]),
					.flag      (flags[g])
				);
			end
		end
	endgenerate

	// Host port: data captured on the strobe, writes have no effect here.
	always_comb begin
		s_d = s_q;
		s_d.flags   = flags;
		s_d.rd_prev = RD_STB && (ADDR == fan_event_pkg::STATUS_TWO_ADDR);
		if (RD_STB) begin
			if (ADDR == fan_event_pkg::STATUS_TWO_ADDR) begin
				s_d.rdata = flags;
			end else if (ADDR == fan_event_pkg::VOLT_CODE_ADDR) begin
				s_d.rdata = {3'h0, code_sync_q};
			end else begin
				s_d.rdata = 8'h00;
			end
		end
	end

	// Port state register; read data stay until the next read strobe.
	always_ff @(posedge MCLK or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign RDATA                 = s_q.rdata;
	assign SECOND_STATUS_SUMMARY = |flags;
	// Started diode fault loads the fault value so the limit error follows.
	assign DIODE_FORCE       = {START && DIODE_TWO_FAULT, START && DIODE_ONE_FAULT};
	assign DIODE_FORCE_VALUE = fan_event_pkg::DIODE_FAULT_VALUE;
	assign DIODE_LIMIT_CLR   = {en_prev_q[fan_event_pkg::DIODE2_BIT] &&
		!ENABLES[fan_event_pkg::DIODE2_BIT], en_prev_q[fan_event_pkg::DIODE1_BIT] &&
		!ENABLES[fan_event_pkg::DIODE1_BIT]};

	// Summary follows the flag registers directly; the reserved bit is a constant zero.
	a_summary_tracks: assert property (@(posedge MCLK) disable iff (!rst_n_i)
		SECOND_STATUS_SUMMARY == (flags != 8'h00))
		else $error("Summary does not track flags.");
	a_rsvd_zero: assert property (@(posedge MCLK) disable iff (!rst_n_i)
		flags[fan_event_pkg::RSVD_BIT] == 1'b0)
		else $error("Reserved bit set.");

	// A write must leave both the flags and the last read data alone.
	a_write_ignored: assert property (@(posedge MCLK) disable iff (!rst_n_i)
		WR_STB && !RD_STB && !rd_clear && !START && ENABLES == $past(ENABLES)
		|=> flags == $past(flags))
		else $error("Write changed flags.");
	a_write_rdata: assert property (@(posedge MCLK) disable iff (!rst_n_i)
		WR_STB && !RD_STB |=> RDATA == $past(RDATA))
		else $error("Write changed read data.");

	// Read path: data are captured first, the clear strobe follows one cycle later.
	a_read_data: assert property (@(posedge MCLK) disable iff (!rst_n_i)
		RD_STB && ADDR == fan_event_pkg::STATUS_TWO_ADDR |=> RDATA == $past(flags))
		else $error("Read data wrong.");
	a_clear_after: assert property (@(posedge MCLK) disable iff (!rst_n_i)
		RD_STB && ADDR == fan_event_pkg::STATUS_TWO_ADDR |=> rd_clear)
		else $error("Clear strobe missing.");
	a_read_clear: assert property (@(posedge MCLK) disable iff (!rst_n_i)
		rd_clear && !cond[fan_event_pkg::RAIL_BIT] && !upd[fan_event_pkg::RAIL_BIT]
		|=> !flags[fan_event_pkg::RAIL_BIT])
		else $error("Read left an ended rail event set.");
	a_code_read: assert property (@(posedge MCLK) disable iff (!rst_n_i)
		RD_STB && ADDR == fan_event_pkg::VOLT_CODE_ADDR
		|=> RDATA == {3'h0, $past(code_sync_q)})
		else $error("Code register read wrong.");

	// Setting needs start, the individual enable and a reading update.
	a_stopped_quiet: assert property (@(posedge MCLK) disable iff (!rst_n_i)
		!$past(START) |-> (flags & ~$past(flags)) == 8'h00)
		else $error("Flag set while stopped.");
	a_no_rise_disabled: assert property (@(posedge MCLK) disable iff (!rst_n_i)
		(flags & ~s_q.flags & ~$past(ENABLES)) == 8'h00)
		else $error("Flag rose while its enable was low.");
	a_rail_set: assert property (@(posedge MCLK) disable iff (!rst_n_i)
		START && ENABLES[fan_event_pkg::RAIL_BIT] && RAIL.rail_update &&
		((RAIL.rail_reading <= RAIL.rail_low) ||
		(RAIL.rail_reading > RAIL.rail_high)) |=> flags[fan_event_pkg::RAIL_BIT])
		else $error("Rail limit event not flagged.");
	a_fan_set: assert property (@(posedge MCLK) disable iff (!rst_n_i)
		START && ENABLES[fan_event_pkg::FAN_BIT0] && FANS[0].update &&
		(FANS[0].count > FANS[0].minimum) |=> flags[fan_event_pkg::FAN_BIT0])
		else $error("Slow fan not flagged.");

	// Enable handling: a disabled flag clears on an update, but holds while stopped.
	a_disabled_clear: assert property (@(posedge MCLK) disable iff (!rst_n_i)
		START && FANS[3].update && !ENABLES[fan_event_pkg::FAN_BIT0 + 3]
		|=> !flags[fan_event_pkg::FAN_BIT0 + 3])
		else $error("Disabled flag kept after update.");
	a_stopped_hold: assert property (@(posedge MCLK) disable iff (!rst_n_i)
		!START && !rd_clear && flags[fan_event_pkg::FAN_BIT0 + 3]
		|=> flags[fan_event_pkg::FAN_BIT0 + 3])
		else $error("Flag dropped while stopped.");

	// Diode flags: the enable clears them at once, a read never while faulted.
	a_diode_dis_clear: assert property (@(posedge MCLK) disable iff (!rst_n_i)
		DIODE_LIMIT_CLR != 2'b00
		|=> (flags[fan_event_pkg::DIODE2_BIT:fan_event_pkg::DIODE1_BIT] &
		$past(DIODE_LIMIT_CLR)) == 2'b00)
		else $error("Diode flag kept after enable dropped.");
	a_diode_persist: assert property (@(posedge MCLK) disable iff (!rst_n_i)
		rd_clear && DIODE_ONE_FAULT && ENABLES[fan_event_pkg::DIODE1_BIT] &&
		flags[fan_event_pkg::DIODE1_BIT] |=> flags[fan_event_pkg::DIODE1_BIT])
		else $error("Read cleared a persisting diode fault.");
	a_diode_force: assert property (@(posedge MCLK) disable iff (!rst_n_i)
		START && DIODE_ONE_FAULT |-> DIODE_FORCE[0])
		else $error("Diode force missing.");

	c_rail_set: cover property (@(posedge MCLK) $rose(flags[0]));
	c_fan_set: cover property (@(posedge MCLK) $rose(flags[2]));
	c_read_clear: cover property (@(posedge MCLK) rd_clear ##1 flags == 8'h00);
	c_diode_set: cover property (@(posedge MCLK) $rose(flags[6]));
	c_diode_disable: cover property (@(posedge MCLK) DIODE_LIMIT_CLR != 2'b00);
endmodule : fan_voltage_event_status

// ===== sim/host_port_model.sv
// Host port model issuing single-strobe register reads and writes.
`timescale 1ns/1ps
module host_port_model (
	input  wire logic       clk,    // Block clock.
	input  wire logic [7:0] rdata,  // Read data from the block.
	output logic [7:0]      addr,   // Register address.
	output logic            rd_stb, // Read strobe.
	output logic            wr_stb  // Write strobe.
);
	// The port idles with both strobes low from time zero.
	initial begin
		addr = 8'h00;
		rd_stb = 1'b0;
		wr_stb = 1'b0;
	end
	// One strobe per read; the clear lands before the data are sampled, then one idle cycle follows.
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk);
		addr = a;
		rd_stb = 1'b1;
		@(negedge clk);
		rd_stb = 1'b0;
		@(negedge clk);
		d = rdata;
		@(negedge clk);
	endtask : rd
	// A write carries no data; the block must ignore it.
	task automatic wr(input logic [7:0] a);
		@(negedge clk);
		addr = a;
		wr_stb = 1'b1;
		@(negedge clk);
		wr_stb = 1'b0;
	endtask : wr
endmodule : host_port_model

// ===== sim/fan_voltage_event_status_tb.sv
// Self-checking bench for the second event status and voltage code registers.
`timescale 1ns/1ps
module fan_voltage_event_status_tb;
	logic                         mclk = 1'b0;
	logic                         rst_n = 1'b0;
	logic                         start = 1'b0;
	logic [7:0]                   en = 8'hff;
	fan_event_pkg::rail_in_t      rail = '0;
	fan_event_pkg::fan_in_t [3:0] fans = '0;
	logic                         f1 = 1'b0;
	logic                         f2 = 1'b0;
	logic [1:0]                   dupd = 2'b00;
	logic [4:0]                   code = 5'h15;
	logic [7:0]                   addr, rdata, fval;
	logic                         rd, wr, summ;
	logic [1:0]                   frc, lclr;
	logic [1:0]                   lclr_seen = 2'b00;
	int                           n_mismatch = 0;
	int                           n_checks = 0;
	// Clock at 10 MHz.
	always #50 mclk = ~mclk;
	// The limit-clear output is a short pulse, so it is remembered here.
	always @(posedge mclk) lclr_seen <= lclr_seen | lclr;
	fan_voltage_event_status u_fan_voltage_event_status (.MCLK(mclk), .RST_N(rst_n),
		.START(start), .ENABLES(en), .RAIL(rail), .FANS(fans), .DIODE_ONE_FAULT(f1),
		.DIODE_TWO_FAULT(f2), .DIODE_UPDATE(dupd), .CPU_VOLTAGE_CODE(code), .ADDR(addr),
		.RD_STB(rd), .WR_STB(wr), .RDATA(rdata), .SECOND_STATUS_SUMMARY(summ),
		.DIODE_FORCE(frc), .DIODE_FORCE_VALUE(fval), .DIODE_LIMIT_CLR(lclr));
	host_port_model u_host_port_model (.clk(mclk), .rdata(rdata), .addr(addr),
		.rd_stb(rd), .wr_stb(wr));
	// Compare and count.
	task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	// Read a register and compare it.
	task automatic rr(input logic [7:0] a, input logic [7:0] e, input string nm);
		logic [7:0] d;
		u_host_port_model.rd(a, d);
		check(nm, d, e);
	endtask : rr
	// Pulse every reading-update strobe for one cycle.
	task automatic upd;
		@(negedge mclk);
		rail.rail_update = 1'b1;
		for (int i = 0; i < 4; i++) fans[i].update = 1'b1;
		dupd = 2'b11;
		@(negedge mclk);
		rail.rail_update = 1'b0;
		for (int i = 0; i < 4; i++) fans[i].update = 1'b0;
		dupd = 2'b00;
	endtask : upd
	// Print the counts and the verdict, then end the run.
	task automatic complete_run;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : complete_run
	// A hang is cut short and counted.
	initial begin
		#1000000;
		n_mismatch++;
		complete_run();
	end
	// Main sequence; inputs move on the falling edge.
	initial begin
		rail.rail_reading = 8'h80;
		rail.rail_low = 8'h40;
		rail.rail_high = 8'hc0;
		for (int i = 0; i < 4; i++) fans[i].minimum = 16'h1000;
		repeat (6) @(negedge mclk);
		rst_n = 1'b1;
		repeat (4) @(negedge mclk);
		rr(8'h42, 8'h00, "status reset");
		rr(8'h43, 8'h15, "code");
		u_host_port_model.wr(8'h43);
		rr(8'h43, 8'h15, "code after write");
		code = 5'h0a;
		repeat (3) @(negedge mclk);
		rr(8'h43, 8'h0a, "code follows pins");
		rail.rail_reading = 8'h40;
		fans[0].count = 16'h1001;
		fans[1].count = 16'h1000;
		fans[2].count = 16'hffff;
		fans[3].count = 16'h1001;
		f1 = 1'b1;
		f2 = 1'b1;
		upd();
		rr(8'h42, 8'h00, "stopped");
		check("no force stopped", {6'h00, frc}, 8'h00);
		start = 1'b1;
		upd();
		check("force", {6'h00, frc}, 8'h03);
		check("force value", fval, 8'h80);
		rail.rail_reading = 8'h80;
		for (int i = 0; i < 4; i++) fans[i].count = 16'h0000;
		repeat (3) @(negedge mclk);
		check("summary held", {7'h00, summ}, 8'h01);
		u_host_port_model.wr(8'h42);
		rr(8'h42, 8'hf5, "status flags");
		rr(8'h42, 8'hc0, "diode persists");
		en = 8'h3f;
		repeat (3) @(negedge mclk);
		check("limit clear", {6'h00, lclr_seen}, 8'h03);
		upd();
		rr(8'h42, 8'h00, "disabled");
		check("summary clear", {7'h00, summ}, 8'h00);
		f1 = 1'b0;
		f2 = 1'b0;
		en = 8'hff;
		fans[3].count = 16'h1001;
		upd();
		fans[3].count = 16'h0000;
		en = 8'hdf;
		repeat (2) @(negedge mclk);
		check("kept till update", {7'h00, summ}, 8'h01);
		upd();
		check("cleared on update", {7'h00, summ}, 8'h00);
		en = 8'hff;
		fans[3].count = 16'h1001;
		upd();
		fans[3].count = 16'h0000;
		start = 1'b0;
		en = 8'hdf;
		upd();
		check("kept while stopped", {7'h00, summ}, 8'h01);
		start = 1'b1;
		upd();
		check("cleared after start", {7'h00, summ}, 8'h00);
		// Reset in mid-run must drop a live flag and the summary bit.
		fans[0].count = 16'h1001;
		upd();
		check("set before reset", {7'h00, summ}, 8'h01);
		rst_n = 1'b0;
		repeat (2) @(negedge mclk);
		check("summary in reset", {7'h00, summ}, 8'h00);
		fans[0].count = 16'h0000;
		rst_n = 1'b1;
		repeat (4) @(negedge mclk);
		rr(8'h42, 8'h00, "status after reset");
		complete_run();
	end
endmodule : fan_voltage_event_status_tb
